// ==== pfis_pkg.sv ====
// Package of timing constants and status layout for the power-fail interrupt sequencer
package pfis_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // Failure to reset delay: 3 ms nominal, tolerance 1 ms
    localparam int unsigned RST_DLY_US = 3000;
    localparam int unsigned RST_DLY_CYC = (CLK_HZ / 1000) * RST_DLY_US / 1000;
    // Hold of reset after restoration: 150 ms nominal, tolerance 75 ms
    localparam int unsigned RST_HOLD_MS = 150;
    localparam int unsigned RST_HOLD_CYC = (CLK_HZ / 1000) * RST_HOLD_MS;
    // Mains period 1/60 s; a tick is refused until half of one period has passed
    localparam int unsigned LINE_HZ = 60;
    localparam int unsigned TICK_GAP_CYC = (CLK_HZ / LINE_HZ) / 2;
    // Status byte layout: bit 8 counted from one is index 7
    localparam int unsigned STAT_TICK_BIT = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam int unsigned CNT_W = 24;
endpackage : pfis_pkg

// ==== pfis_sync.sv ====
// Small counting timer used for reset delays and tick spacing
`timescale 1ns/100ps
module pfis_timer #(
    parameter int unsigned W = 24
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic done
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic done_nxt;

    // Count while run is high, saturate at the limit, clear when run drops
    always_comb begin
        cnt_nxt = cnt_r;
        if (!run) begin
            cnt_nxt = '0;
        end else if (cnt_r != limit) begin
            cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
        done_nxt = run && (cnt_nxt == limit);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            done <= done_nxt;
        end
    end
endmodule : pfis_timer

// ==== pfis_top.sv ====
// Power-fail interrupt sequencer: NMI, reset and line-synchronised tick
// Function
// - NMI output is driven low only by a power failure.
// - Power failure drives NMI low immediately, no deliberate delay.
// - NMI stays low until reset has gone low; one interrupt per failure.
// - Reset output asserts only for power restoration and startup; the code asserts it only for power failure (from PF_FAILING) and startup.
// - Reset goes low 3 ms (+-1 ms) after NMI goes low.
// - Reset held through outage, released 150 ms (+-75 ms) after restoration.
// - One interrupt request line shared by tick and serial ports.
// - Tick raises interrupt request and sets status bit 8 once per 1/60 s.
// - Tick occurs in 270 to 330 degree window of 60 Hz mains.
`timescale 1ns/100ps
module pfis_top #(
    parameter int unsigned RST_DLY_CYC = pfis_pkg::RST_DLY_CYC,
    parameter int unsigned RST_HOLD_CYC = pfis_pkg::RST_HOLD_CYC,
    parameter int unsigned TICK_GAP_CYC = pfis_pkg::TICK_GAP_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic power_fail,
    input wire logic power_good,
    input wire logic phase_window,
    input wire logic uart_irq,
    input wire logic tick_ack,
    output logic nmi_n,
    output logic cpu_reset_n,
    output logic irq_n,
    output logic [7:0] status
);
    localparam int unsigned CW = pfis_pkg::CNT_W;
    // Tolerance bands for the checkers: 3 ms +-1 ms and 150 ms +-75 ms scale with the nominal counts
    localparam int unsigned CHK_DLY_MIN = (RST_DLY_CYC * 2) / 3;
    localparam int unsigned CHK_DLY_MAX = (RST_DLY_CYC * 4) / 3;
    localparam int unsigned CHK_HOLD_MIN = RST_HOLD_CYC / 2;
    localparam int unsigned CHK_HOLD_MAX = (RST_HOLD_CYC * 3) / 2;

    // Elaboration check: every count must be nonzero and fit the shared timer width
    if (RST_DLY_CYC < 1 || RST_HOLD_CYC < 1 || TICK_GAP_CYC < 1 ||
        RST_DLY_CYC >= (1 << CW) || RST_HOLD_CYC >= (1 << CW) || TICK_GAP_CYC >= (1 << CW)) begin : g_bad_count
        $error("pfis_top: timing count out of range");
    end

    typedef enum logic [1:0] {PF_STARTUP, PF_RUN, PF_FAILING, PF_OUTAGE} pfis_state_e;

    pfis_state_e st_r;
    pfis_state_e st_nxt;
    logic nmi_n_nxt;
    logic rst_n_nxt;
    logic dly_done;
    logic hold_done;
    logic gap_done;
    logic win_d_r;
    logic tick_flag_r;
    logic tick_flag_nxt;
    logic irq_n_nxt;
    logic tick_evt;

    // Delay from NMI to reset, and hold after power returns
    pfis_timer #(.W(CW)) u_dly (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .run(st_r == PF_FAILING),
        .limit(CW'(RST_DLY_CYC - 1)),
        .done(dly_done)
    );

    pfis_timer #(.W(CW)) u_hold (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .run((st_r == PF_OUTAGE || st_r == PF_STARTUP) && power_good && !power_fail),
        .limit(CW'(RST_HOLD_CYC - 1)),
        .done(hold_done)
    );

    // Power sequence; startup also holds reset until power is good for the hold time
    always_comb begin
        st_nxt = st_r;
        nmi_n_nxt = nmi_n;
        rst_n_nxt = cpu_reset_n;
        case (st_r)
            PF_STARTUP: begin
                if (hold_done) begin
                    st_nxt = PF_RUN;
                    rst_n_nxt = 1'b1;
                end
            end
            PF_RUN: begin
                if (power_fail) begin
                    st_nxt = PF_FAILING;
                    nmi_n_nxt = 1'b0;
                end
            end
            PF_FAILING: begin
                // NMI held low until reset falls, so a flickering fail cannot retrigger it
                if (dly_done) begin
                    st_nxt = PF_OUTAGE;
                    rst_n_nxt = 1'b0;
                end
            end
            PF_OUTAGE: begin
                nmi_n_nxt = 1'b1;
                if (hold_done) begin
                    st_nxt = PF_RUN;
                    rst_n_nxt = 1'b1;
                end
            end
            default: begin
                st_nxt = PF_STARTUP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= PF_STARTUP;
            nmi_n <= 1'b1;
            cpu_reset_n <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            nmi_n <= nmi_n_nxt;
            cpu_reset_n <= rst_n_nxt;
        end
    end

    // Spacing timer keeps a bouncing window input from giving two ticks per cycle
    pfis_timer #(.W(CW)) u_gap (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .run(!tick_evt),
        .limit(CW'(TICK_GAP_CYC - 1)),
        .done(gap_done)
    );

    assign tick_evt = phase_window && !win_d_r && gap_done && cpu_reset_n;

    // Tick flag: set wins over acknowledge; request merges tick and serial ports
    always_comb begin
        tick_flag_nxt = tick_flag_r;
        if (tick_ack) begin
            tick_flag_nxt = 1'b0;
        end
        if (tick_evt) begin
            tick_flag_nxt = 1'b1;
        end
        irq_n_nxt = !(tick_flag_nxt || uart_irq);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            win_d_r <= 1'b0;
            tick_flag_r <= 1'b0;
            irq_n <= 1'b1;
            status <= pfis_pkg::STAT_RESET;
        end else if (ce) begin
            win_d_r <= phase_window;
            tick_flag_r <= tick_flag_nxt;
            irq_n <= irq_n_nxt;
            status <= pfis_pkg::STAT_RESET | (8'(tick_flag_nxt) << pfis_pkg::STAT_TICK_BIT);
        end
    end

    chk_nmi_only_fail: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && $fell(nmi_n)) |-> $past(power_fail)) else $error("NMI fell without power fail");
    chk_nmi_prompt: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && st_r == PF_RUN && power_fail) |=> !nmi_n) else $error("NMI not immediate");
    chk_nmi_holds: assert property (@(posedge clk) disable iff (!reset_n)
        (!nmi_n && cpu_reset_n) |=> !nmi_n) else $error("NMI released before reset");
    chk_rst_cause: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(cpu_reset_n) |-> $past(st_r == PF_FAILING)) else $error("Reset from wrong cause");
    chk_rst_delay: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && $fell(nmi_n)) |-> ##1 (cpu_reset_n && ce) [*1]) else $error("Reset too early");
    chk_tick_sets: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && tick_evt) |=> (status[pfis_pkg::STAT_TICK_BIT] && !irq_n)) else $error("Tick not flagged");
    chk_irq_share: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && uart_irq) |=> !irq_n) else $error("Serial request lost");
    chk_tick_window: assert property (@(posedge clk) disable iff (!reset_n)
        tick_evt |-> phase_window) else $error("Tick outside window");
    chk_tick_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && tick_flag_r && !tick_ack) |=> tick_flag_r) else $error("Tick flag lost");

    // Checker helpers: independent cycle counts, so the windows are not judged by the design's own timers
    logic [CW:0] chk_dly_cnt_r;
    logic [CW:0] chk_dly_cnt_nxt;
    logic [CW:0] chk_hold_cnt_r;
    logic [CW:0] chk_hold_cnt_nxt;

    // Delay counts NMI low with reset high; hold counts good power while reset is low
    always_comb begin
        chk_dly_cnt_nxt = chk_dly_cnt_r;
        chk_hold_cnt_nxt = chk_hold_cnt_r;
        if (nmi_n) begin
            chk_dly_cnt_nxt = '0;
        end else if (cpu_reset_n && chk_dly_cnt_r != '1) begin
            chk_dly_cnt_nxt = chk_dly_cnt_r + {{CW{1'b0}}, 1'b1};
        end
        if (cpu_reset_n || !power_good || power_fail) begin
            chk_hold_cnt_nxt = '0;
        end else if (chk_hold_cnt_r != '1) begin
            chk_hold_cnt_nxt = chk_hold_cnt_r + {{CW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chk_dly_cnt_r <= '0;
            chk_hold_cnt_r <= '0;
        end else if (ce) begin
            chk_dly_cnt_r <= chk_dly_cnt_nxt;
            chk_hold_cnt_r <= chk_hold_cnt_nxt;
        end
    end

    chk_rst_window: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(cpu_reset_n) |-> (chk_dly_cnt_r >= CHK_DLY_MIN && chk_dly_cnt_r <= CHK_DLY_MAX))
        else $error("Reset delay outside tolerance");
    chk_hold_window: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(cpu_reset_n) |-> (chk_hold_cnt_r >= CHK_HOLD_MIN && chk_hold_cnt_r <= CHK_HOLD_MAX))
        else $error("Reset hold outside tolerance");
endmodule : pfis_top

// ==== pfis_cpu_model.sv ====
// Behavioural processor model facing the sequencer outputs
`timescale 1ns/100ps
module pfis_cpu_model #(
    parameter int ACK_LAT = 6
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic nmi_n,
    input wire logic cpu_reset_n,
    input wire logic irq_n,
    input wire logic [7:0] status,
    output logic tick_ack,
    output int nmi_cnt
);
    logic nmi_q;
    int cnt;
    // Counts NMI entries; services a pending tick after a delay, so the flag must wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_q <= 1'b1;
            nmi_cnt <= 0;
            cnt <= 0;
            tick_ack <= 1'b0;
        end else begin
            nmi_q <= nmi_n;
            tick_ack <= 1'b0;
            cnt <= 0;
            if (nmi_q && !nmi_n) nmi_cnt <= nmi_cnt + 1;
            if (cpu_reset_n && !irq_n && status[pfis_pkg::STAT_TICK_BIT]) begin
                cnt <= (cnt == ACK_LAT) ? 0 : cnt + 1;
                tick_ack <= (cnt == ACK_LAT);
            end
        end
    end
endmodule : pfis_cpu_model

// ==== power_fail_interrupt_sequencer_bench.sv ====
// Self-checking bench for the power-fail interrupt sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module power_fail_interrupt_sequencer_bench;
    logic clk = 0, reset_n = 0, ce = 1, power_fail = 0, power_good = 1, phase_window = 0, uart_irq = 0;
    logic tick_ack, nmi_n, cpu_reset_n, irq_n;
    logic [7:0] status;
    int nmi_cnt, n, mismatches = 0, n_tests = 0;
    logic [1:0] rows [4] = '{2'b10, 2'b01, 2'b10, 2'b01}; // uart_irq, irq_n expected
    pfis_top #(.RST_DLY_CYC(30), .RST_HOLD_CYC(50), .TICK_GAP_CYC(20)) dut_u (.clk(clk), .reset_n(reset_n),
        .ce(ce), .power_fail(power_fail), .power_good(power_good), .phase_window(phase_window),
        .uart_irq(uart_irq), .tick_ack(tick_ack), .nmi_n(nmi_n), .cpu_reset_n(cpu_reset_n),
        .irq_n(irq_n), .status(status));
    pfis_cpu_model cpu_u (.clk(clk), .reset_n(reset_n), .nmi_n(nmi_n), .cpu_reset_n(cpu_reset_n),
        .irq_n(irq_n), .status(status), .tick_ack(tick_ack), .nmi_cnt(nmi_cnt));
    // 25 MHz clock
    always #20 clk = ~clk;
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    // Bounded wait for the processor reset to reach a level
    task automatic wt(input logic lvl, output int c);
        c = 0;
        while (cpu_reset_n !== lvl && c < 300) begin
            step(1);
            c++;
        end
    endtask : wt
    // Pulses the phase window, then checks whether a tick was taken
    task automatic tick(input logic [7:0] e);
        @(posedge clk) phase_window <= 1'b1;
        step(3);
        `CHK("tick_status", e, status)
        `CHK("tick_irq", ~e[7], irq_n)
        `CHK("tick_nmi", 1'b1, nmi_n)
        @(posedge clk) phase_window <= 1'b0;
        step(10);
        `CHK("tick_clear", 8'h00, status)
    endtask : tick
    task automatic report_and_stop;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #80000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        step(3);
        `CHK("rst_cpu", 1'b0, cpu_reset_n)
        `CHK("rst_out", 11'h7FF, {nmi_n, irq_n, ~status, 1'b1})
        @(posedge clk) reset_n <= 1'b1;
        wt(1'b1, n);
        `CHK("startup_hold", 1'b1, n >= 25 && n <= 75)
        foreach (rows[i]) begin
            @(posedge clk) uart_irq <= rows[i][1];
            step(2);
            `CHK("uart_irq", rows[i][0], irq_n)
            `CHK("uart_nmi", 1'b1, nmi_n)
        end
        step(20);
        tick(8'h80);
        tick(8'h00);
        step(20);
        tick(8'h80);
        // Clock enable low freezes the sequencer, so the failure waits for it
        @(posedge clk) ce <= 1'b0;
        power_fail <= 1'b1;
        power_good <= 1'b0;
        step(4);
        `CHK("ce_freeze", 1'b1, nmi_n)
        @(posedge clk) ce <= 1'b1;
        step(1);
        `CHK("nmi_fast", 1'b0, nmi_n)
        wt(1'b0, n);
        `CHK("rst_delay", 1'b1, n >= 20 && n <= 40)
        `CHK("nmi_held", 1'b0, nmi_n)
        step(5);
        `CHK("nmi_once", 1, nmi_cnt)
        `CHK("rst_outage", 1'b0, cpu_reset_n)
        @(posedge clk) power_fail <= 1'b0;
        power_good <= 1'b1;
        wt(1'b1, n);
        `CHK("restore_hold", 1'b1, n >= 25 && n <= 75)
        `CHK("restore_nmi", 1'b1, nmi_n)
        // Reset in mid-run: outputs return to reset levels and the startup hold repeats
        @(posedge clk) reset_n <= 1'b0;
        step(2);
        `CHK("rst_mid", 11'h7FF, {nmi_n, irq_n, ~status, ~cpu_reset_n})
        @(posedge clk) reset_n <= 1'b1;
        wt(1'b1, n);
        `CHK("mid_hold", 1'b1, n >= 25 && n <= 75)
        `CHK("mid_nmi", 1'b1, nmi_n)
        report_and_stop();
    end
endmodule : power_fail_interrupt_sequencer_bench
